/* dpo_dpll.sv */
// Phase offset, recalibration and measurement logic of one loop, with an AXI4-Lite register slave.
// Contract
// R01: Programmed phase offset takes effect only while build-out is disabled; the recalibration ramp back still targets it with build-out enabled.
// R02: Offset spans plus or minus 200 ns in 6 ps steps.
// R03: Offset enters the feedback path and slews at a bandwidth-set rate.
// R04: Offset written in free-run or holdover waits until locking begins; the recalibration ramp back still targets it in those states.
// R05: Setting the recalibrate trigger starts a recalibration run.
// R06: Recalibration: mini-holdover, ramp to zero, divider reset, ramp back, exit.
// R07: Offset rewritten during recalibration becomes the final ramp target.
// R08: Frequency readback covers plus or minus 80 ppm at fine resolution when locked.
// R09: Frequency readback is the loop integral, averaged per loop bandwidth.
// R10: Frequency readback is corrected by the master oscillator adjustment.
// R11: Phase readback is reference against feedback, averaged by a low-pass filter.
// R12: Inter-reference mode stops locking and compares both loops' references.
// R13: Software picks compared inputs with equal frequency at the detector.
// R14: Output-versus-reference mode measures other loop output against own reference.
// R15: Measurement modes in this loop do not disturb the other loop.
// R16: Software should force reference selection while measuring.
// R17: Input is declared invalid when frequency exceeds the hard limit.
// R18: Loop bandwidth select sets the transfer corner.
// R19: Phase readback is in degrees, offset in picoseconds.
// R20: Recalibrate trigger clears itself when the sequence completes.
//
// The register addresses and the AXI4-Lite slave port were left to the implementer.
`timescale 1ns/1ps
module dpo_dpll (
  input wire logic mclk,
  input wire logic rst,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [1:0] loop_state,
  input wire logic phase_sample_valid,
  input wire logic signed [15:0] own_ref_phase,
  input wire logic signed [15:0] feedback_phase,
  input wire logic signed [15:0] other_ref_phase,
  input wire logic signed [15:0] other_out_phase,
  output logic signed [16:0] fb_phase_offset,
  output logic lock_enable,
  output logic mini_holdover,
  output logic divider_reset,
  output logic [2:0] pd_select,
  output logic [3:0] forced_reference_select,
  output logic [3:0] loop_bw_select,
  output logic ref_invalid
);

  dpo_recal_if rc ();

  dpo_recal_seq i_dpo_recal_seq (
    .mclk(mclk),
    .rst(rst),
    .rc(rc.seq)
  );

  // ---------------------------------------------------------------------------
  // Bus slave and register state
  // ---------------------------------------------------------------------------
  logic aw_hold_ff, w_hold_ff, awready_ff, wready_ff, bvalid_ff, arready_ff, rvalid_ff;
  logic nxt_aw_hold, nxt_w_hold, nxt_awready, nxt_wready, nxt_bvalid, nxt_arready, nxt_rvalid;
  logic [7:0] awaddr_ff, nxt_awaddr;
  logic [31:0] wdata_ff, nxt_wdata, rdata_ff, nxt_rdata, wr_val;
  logic [3:0] wstrb_ff, nxt_wstrb;
  logic [1:0] bresp_ff, nxt_bresp, rresp_ff, nxt_rresp;
  logic [11:0] ctrl_ff, nxt_ctrl;
  logic signed [16:0] offset_ff, nxt_offset;
  logic [31:0] mcadj_ff, nxt_mcadj, hardlim_ff, nxt_hardlim, status_w;
  logic do_write;

  // Byte-lane merge of a write into an existing word.
  function automatic logic [31:0] merge_bytes(input logic [31:0] old, input logic [31:0] data,
                                              input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[8*i +: 8] = data[8*i +: 8];
      end
    end
    return res;
  endfunction

  // Clamp a signed word to the offset range.
  function automatic logic signed [16:0] clamp_offset(input logic [31:0] v);
    logic signed [31:0] s;
    s = $signed(v);
    if (s > 32'(dpo_pkg::OFFSET_MAX)) begin
      return dpo_pkg::OFFSET_MAX;
    end else if (s < -32'(dpo_pkg::OFFSET_MAX)) begin
      return -dpo_pkg::OFFSET_MAX;
    end
    return s[16:0];
  endfunction

  logic signed [31:0] freq_read_ff;
  logic signed [15:0] phase_avg_ff;
  logic ref_invalid_ff, lock_en_ff;
  dpo_pkg::dpo_pd_type pd_sel_ff;

  assign status_w = {24'h000000, ref_invalid_ff, rc.busy, rc.mini_holdover, lock_en_ff, 2'b00, loop_state};

  // Address and data are held separately so they may arrive in either order.
  always_comb begin
    nxt_aw_hold = aw_hold_ff;
    nxt_w_hold = w_hold_ff;
    nxt_awaddr = awaddr_ff;
    nxt_wdata = wdata_ff;
    nxt_wstrb = wstrb_ff;
    nxt_bvalid = bvalid_ff;
    nxt_bresp = bresp_ff;
    nxt_rvalid = rvalid_ff;
    nxt_rdata = rdata_ff;
    nxt_rresp = rresp_ff;
    nxt_ctrl = ctrl_ff;
    nxt_offset = offset_ff;
    nxt_mcadj = mcadj_ff;
    nxt_hardlim = hardlim_ff;
    wr_val = 32'h00000000;
    do_write = aw_hold_ff && w_hold_ff && !bvalid_ff;
    if (s_axi_awvalid && awready_ff) begin
      nxt_aw_hold = 1'b1;
      nxt_awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && wready_ff) begin
      nxt_w_hold = 1'b1;
      nxt_wdata = s_axi_wdata;
      nxt_wstrb = s_axi_wstrb;
    end
    if (bvalid_ff && s_axi_bready) begin
      nxt_bvalid = 1'b0;
    end
    // The sequencer's done clears the trigger first, so a control write in the same cycle that sets the bit re-arms it.
    if (rc.done) begin
      nxt_ctrl[dpo_pkg::CTRL_RECAL_BIT] = 1'b0; // R20
    end
    if (do_write) begin
      nxt_aw_hold = 1'b0;
      nxt_w_hold = 1'b0;
      nxt_bvalid = 1'b1;
      nxt_bresp = dpo_pkg::RESP_OKAY;
      unique case (awaddr_ff)
        dpo_pkg::ADDR_CTRL: begin
          wr_val = merge_bytes({20'h00000, ctrl_ff}, wdata_ff, wstrb_ff);
          nxt_ctrl = wr_val[11:0];
          nxt_ctrl[dpo_pkg::CTRL_RECAL_BIT] = wr_val[dpo_pkg::CTRL_RECAL_BIT] |
                                              (ctrl_ff[dpo_pkg::CTRL_RECAL_BIT] && !rc.done); // R05
        end
        dpo_pkg::ADDR_OFFSET: begin
          wr_val = merge_bytes({{15{offset_ff[16]}}, offset_ff}, wdata_ff, wstrb_ff);
          nxt_offset = clamp_offset(wr_val); // R02
        end
        dpo_pkg::ADDR_MCADJ: begin
          nxt_mcadj = merge_bytes(mcadj_ff, wdata_ff, wstrb_ff);
        end
        dpo_pkg::ADDR_HARDLIM: begin
          nxt_hardlim = merge_bytes(hardlim_ff, wdata_ff, wstrb_ff);
        end
        dpo_pkg::ADDR_FREQ, dpo_pkg::ADDR_PHASE, dpo_pkg::ADDR_STATUS: begin
          nxt_bresp = dpo_pkg::RESP_OKAY;
        end
        default: begin
          nxt_bresp = dpo_pkg::RESP_SLVERR;
        end
      endcase
    end
    if (rvalid_ff && s_axi_rready) begin
      nxt_rvalid = 1'b0;
    end
    if (s_axi_arvalid && arready_ff) begin
      nxt_rvalid = 1'b1;
      nxt_rresp = dpo_pkg::RESP_OKAY;
      unique case (s_axi_araddr)
        dpo_pkg::ADDR_CTRL: nxt_rdata = {20'h00000, ctrl_ff};
        dpo_pkg::ADDR_OFFSET: nxt_rdata = {{15{offset_ff[16]}}, offset_ff};
        dpo_pkg::ADDR_FREQ: nxt_rdata = freq_read_ff; // R08
        dpo_pkg::ADDR_PHASE: nxt_rdata = {{16{phase_avg_ff[15]}}, phase_avg_ff}; // R19
        dpo_pkg::ADDR_MCADJ: nxt_rdata = mcadj_ff;
        dpo_pkg::ADDR_HARDLIM: nxt_rdata = hardlim_ff;
        dpo_pkg::ADDR_STATUS: nxt_rdata = status_w;
        default: begin
          nxt_rdata = 32'h00000000;
          nxt_rresp = dpo_pkg::RESP_SLVERR;
        end
      endcase
    end
    nxt_awready = !nxt_aw_hold && !nxt_bvalid;
    nxt_wready = !nxt_w_hold && !nxt_bvalid;
    nxt_arready = !nxt_rvalid;
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      aw_hold_ff <= 1'b0;
      w_hold_ff <= 1'b0;
      awready_ff <= 1'b0;
      wready_ff <= 1'b0;
      bvalid_ff <= 1'b0;
      arready_ff <= 1'b0;
      rvalid_ff <= 1'b0;
      awaddr_ff <= 8'h00;
      wdata_ff <= 32'h00000000;
      wstrb_ff <= 4'h0;
      bresp_ff <= 2'h0;
      rdata_ff <= 32'h00000000;
      rresp_ff <= 2'h0;
      ctrl_ff <= dpo_pkg::CTRL_RST;
      offset_ff <= 17'sh00000;
      mcadj_ff <= 32'h00000000;
      hardlim_ff <= dpo_pkg::HARDLIM_RST;
    end else begin
      aw_hold_ff <= nxt_aw_hold;
      w_hold_ff <= nxt_w_hold;
      awready_ff <= nxt_awready;
      wready_ff <= nxt_wready;
      bvalid_ff <= nxt_bvalid;
      arready_ff <= nxt_arready;
      rvalid_ff <= nxt_rvalid;
      awaddr_ff <= nxt_awaddr;
      wdata_ff <= nxt_wdata;
      wstrb_ff <= nxt_wstrb;
      bresp_ff <= nxt_bresp;
      rdata_ff <= nxt_rdata;
      rresp_ff <= nxt_rresp;
      ctrl_ff <= nxt_ctrl;
      offset_ff <= nxt_offset;
      mcadj_ff <= nxt_mcadj;
      hardlim_ff <= nxt_hardlim;
    end
  end

  // ---------------------------------------------------------------------------
  // Offset ramp, measurement and frequency integral
  // ---------------------------------------------------------------------------
  logic signed [16:0] eff_target_ff, nxt_eff_target, fb_ofs_ff, nxt_fb_ofs, ramp_target, step, diff17;
  logic signed [15:0] pd_err, nxt_phase_avg;
  logic signed [31:0] freq_int_ff, nxt_freq_int, nxt_freq_read, abs_int;
  logic nxt_ref_invalid, nxt_lock_en, locking, build_out;
  dpo_pkg::dpo_pd_type nxt_pd_sel;
  logic [3:0] bw_sel;

  assign build_out = ctrl_ff[dpo_pkg::CTRL_BUILD_OUT_BIT];
  assign bw_sel = ctrl_ff[dpo_pkg::CTRL_BW_LSB +: dpo_pkg::SEL_W];
  assign locking = (loop_state == dpo_pkg::LOOP_LOCKING) || (loop_state == dpo_pkg::LOOP_LOCKED);

  // Measurement modes only re-steer this loop's detector and lock enable; nothing here drives the other loop.
  always_comb begin
    nxt_eff_target = eff_target_ff;
    if (build_out) begin
      nxt_eff_target = 17'sh00000; // R01
    end else if (locking) begin
      nxt_eff_target = offset_ff; // R04
    end
    if (rc.ramp_zero) begin
      ramp_target = 17'sh00000; // R06
    end else if (rc.busy) begin
      ramp_target = offset_ff; // R07
    end else begin
      ramp_target = eff_target_ff;
    end
    // Slew per cycle doubles with each bandwidth step, so a wide loop follows faster.
    step = 17'sh00001 <<< bw_sel; // R03
    diff17 = ramp_target - fb_ofs_ff;
    if (diff17 > step) begin
      nxt_fb_ofs = fb_ofs_ff + step;
    end else if (diff17 < -step) begin
      nxt_fb_ofs = fb_ofs_ff - step;
    end else begin
      nxt_fb_ofs = ramp_target;
    end
    if (ctrl_ff[dpo_pkg::CTRL_INTER_REF_BIT]) begin
      nxt_pd_sel = dpo_pkg::PD_INTER_REF; // R12
      pd_err = own_ref_phase - other_ref_phase;
    end else if (ctrl_ff[dpo_pkg::CTRL_OUT_VS_REF_BIT]) begin
      nxt_pd_sel = dpo_pkg::PD_OUT_VS_REF; // R14
      pd_err = other_out_phase - own_ref_phase;
    end else begin
      nxt_pd_sel = dpo_pkg::PD_NORMAL; // R15
      pd_err = own_ref_phase - feedback_phase;
    end
    nxt_lock_en = !ctrl_ff[dpo_pkg::CTRL_INTER_REF_BIT] && !rc.mini_holdover;
    nxt_phase_avg = phase_avg_ff;
    nxt_freq_int = freq_int_ff;
    if (phase_sample_valid) begin
      nxt_phase_avg = phase_avg_ff + ((pd_err - phase_avg_ff) >>> dpo_pkg::PHASE_AVG_SHIFT); // R11
      if (lock_en_ff && locking) begin
        nxt_freq_int = freq_int_ff + ({{16{pd_err[15]}}, pd_err} <<< bw_sel); // R09 R18
      end
    end
    nxt_freq_read = freq_int_ff + $signed(mcadj_ff); // R10
    abs_int = freq_int_ff[31] ? -freq_int_ff : freq_int_ff;
    nxt_ref_invalid = $unsigned(abs_int) > hardlim_ff; // R17
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      eff_target_ff <= 17'sh00000;
      fb_ofs_ff <= 17'sh00000;
      pd_sel_ff <= dpo_pkg::PD_NORMAL;
      lock_en_ff <= 1'b0;
      phase_avg_ff <= 16'sh0000;
      freq_int_ff <= 32'sh00000000;
      freq_read_ff <= 32'sh00000000;
      ref_invalid_ff <= 1'b0;
    end else begin
      eff_target_ff <= nxt_eff_target;
      fb_ofs_ff <= nxt_fb_ofs;
      pd_sel_ff <= nxt_pd_sel;
      lock_en_ff <= nxt_lock_en;
      phase_avg_ff <= nxt_phase_avg;
      freq_int_ff <= nxt_freq_int;
      freq_read_ff <= nxt_freq_read;
      ref_invalid_ff <= nxt_ref_invalid;
    end
  end

  assign rc.start = ctrl_ff[dpo_pkg::CTRL_RECAL_BIT] && !rc.busy && !rc.done;
  assign rc.at_zero = (fb_ofs_ff == 17'sh00000);
  assign rc.at_target = (fb_ofs_ff == offset_ff);

  assign s_axi_awready = awready_ff;
  assign s_axi_wready = wready_ff;
  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_bresp = bresp_ff;
  assign s_axi_arready = arready_ff;
  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rdata = rdata_ff;
  assign s_axi_rresp = rresp_ff;
  assign fb_phase_offset = fb_ofs_ff;
  assign lock_enable = lock_en_ff;
  assign mini_holdover = rc.mini_holdover;
  assign divider_reset = rc.divider_reset;
  assign pd_select = pd_sel_ff;
  assign forced_reference_select = ctrl_ff[dpo_pkg::CTRL_FORCE_LSB +: dpo_pkg::SEL_W];
  assign loop_bw_select = bw_sel;
  assign ref_invalid = ref_invalid_ff;

  // ---------------------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------------------
  a_pbo_blocks_offset: assert property (@(posedge mclk) disable iff (rst) // R01
    build_out |=> eff_target_ff == 17'sh00000)
    else $error("Offset applied while build-out enabled.");
  a_offset_in_range: assert property (@(posedge mclk) disable iff (rst) // R02
    (fb_ofs_ff <= dpo_pkg::OFFSET_MAX) && (fb_ofs_ff >= -dpo_pkg::OFFSET_MAX))
    else $error("Feedback offset out of range.");
  a_slew_bounded: assert property (@(posedge mclk) disable iff (rst) // R03
    (fb_ofs_ff - $past(fb_ofs_ff) <= $past(step)) && ($past(fb_ofs_ff) - fb_ofs_ff <= $past(step)))
    else $error("Offset slewed faster than the bandwidth step.");
  a_holdover_freeze: assert property (@(posedge mclk) disable iff (rst) // R04
    (!locking && !build_out) |=> $stable(eff_target_ff))
    else $error("Offset target moved outside locking states.");
  a_divrst_at_zero: assert property (@(posedge mclk) disable iff (rst) // R06
    rc.divider_reset |-> fb_ofs_ff == 17'sh00000)
    else $error("Dividers reset with nonzero offset.");
  a_inter_ref_unlock: assert property (@(posedge mclk) disable iff (rst) // R12
    ctrl_ff[dpo_pkg::CTRL_INTER_REF_BIT] |=> !lock_en_ff && pd_sel_ff == dpo_pkg::PD_INTER_REF)
    else $error("Loop still locking in inter-reference mode.");
  a_hard_limit: assert property (@(posedge mclk) disable iff (rst) // R17
    ($unsigned(abs_int) > hardlim_ff) |=> ref_invalid_ff)
    else $error("Hard limit exceeded without invalid flag.");
  a_recal_selfclear: assert property (@(posedge mclk) disable iff (rst) // R20
    (rc.done && !do_write) |=> !ctrl_ff[dpo_pkg::CTRL_RECAL_BIT])
    else $error("Recalibrate trigger did not clear.");

endmodule

/* dpo_pkg.sv */
// Constants, register map and state encodings for the loop phase-offset and measurement block.
package dpo_pkg;

  // ---------------------------------------------------------------------------
  // Clock and timing
  // ---------------------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_PS = 10000;
  localparam int unsigned DIVRST_TIME_NS = 100;
  localparam int unsigned DIVRST_CYC = (DIVRST_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam logic [7:0] DIVRST_CYC_W8 = 8'(DIVRST_CYC);

  // ---------------------------------------------------------------------------
  // Register byte addresses
  // ---------------------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_OFFSET = 8'h04;
  localparam logic [7:0] ADDR_FREQ = 8'h08;
  localparam logic [7:0] ADDR_PHASE = 8'h0c;
  localparam logic [7:0] ADDR_MCADJ = 8'h10;
  localparam logic [7:0] ADDR_HARDLIM = 8'h14;
  localparam logic [7:0] ADDR_STATUS = 8'h18;

  // ---------------------------------------------------------------------------
  // Control field positions
  // ---------------------------------------------------------------------------
  localparam int unsigned CTRL_BUILD_OUT_BIT = 0;
  localparam int unsigned CTRL_RECAL_BIT = 1;
  localparam int unsigned CTRL_INTER_REF_BIT = 2;
  localparam int unsigned CTRL_OUT_VS_REF_BIT = 3;
  localparam int unsigned CTRL_FORCE_LSB = 4;
  localparam int unsigned CTRL_BW_LSB = 8;
  localparam int unsigned CTRL_USED_W = 12;

  // ---------------------------------------------------------------------------
  // Widths and reset values
  // ---------------------------------------------------------------------------
  localparam int unsigned OFFSET_W = 17;
  localparam int unsigned PHASE_W = 16;
  localparam int unsigned FREQ_W = 32;
  localparam int unsigned SEL_W = 4;
  localparam int unsigned OFFSET_STEP_PS = 6;
  localparam int unsigned OFFSET_RANGE_NS = 200;
  localparam logic signed [16:0] OFFSET_MAX = 17'(OFFSET_RANGE_NS * 1000 / OFFSET_STEP_PS);
  localparam int unsigned PHASE_AVG_SHIFT = 4;
  localparam logic [11:0] CTRL_RST = 12'h000;
  localparam logic [31:0] HARDLIM_RST = 32'h7fffffff;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ---------------------------------------------------------------------------
  // Encodings
  // ---------------------------------------------------------------------------
  typedef enum logic [1:0] {
    LOOP_FREE_RUN = 2'h0,
    LOOP_HOLDOVER = 2'h1,
    LOOP_LOCKING = 2'h2,
    LOOP_LOCKED = 2'h3
  } dpo_loop_type;

  typedef enum logic [2:0] {
    PD_NORMAL = 3'b001,
    PD_INTER_REF = 3'b010,
    PD_OUT_VS_REF = 3'b100
  } dpo_pd_type;

  typedef enum logic [5:0] {
    RC_IDLE = 6'b000001,
    RC_ENTER = 6'b000010,
    RC_ZERO = 6'b000100,
    RC_DIVRST = 6'b001000,
    RC_BACK = 6'b010000,
    RC_EXIT = 6'b100000
  } dpo_recal_type;

endpackage

/* dpo_recal_if.sv */
// Handshake between the register/datapath top and the recalibration sequencer.
`timescale 1ns/1ps
interface dpo_recal_if;
  logic start;
  logic at_zero;
  logic at_target;
  logic busy;
  logic mini_holdover;
  logic ramp_zero;
  logic divider_reset;
  logic done;

  modport ctl (output start, output at_zero, output at_target,
               input busy, input mini_holdover, input ramp_zero, input divider_reset, input done);
  modport seq (input start, input at_zero, input at_target,
               output busy, output mini_holdover, output ramp_zero, output divider_reset, output done);
endinterface

/* dpo_recal_seq.sv */
// Recalibration sequencer: mini-holdover, ramp to zero, divider reset, ramp back.
`timescale 1ns/1ps
module dpo_recal_seq (
  input wire logic mclk,
  input wire logic rst,
  dpo_recal_if.seq rc
);

  dpo_pkg::dpo_recal_type state_ff, nxt_state;
  logic [7:0] cnt_ff, nxt_cnt;
  logic busy_ff, mh_ff, rz_ff, dr_ff, done_ff;

  // ---------------------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------------------
  // Steps run strictly in order; a new trigger is only taken from idle.
  always_comb begin
    nxt_state = state_ff;
    nxt_cnt = cnt_ff;
    unique case (state_ff)
      dpo_pkg::RC_IDLE: begin
        if (rc.start) begin
          nxt_state = dpo_pkg::RC_ENTER; // R05
        end
      end
      dpo_pkg::RC_ENTER: begin
        nxt_state = dpo_pkg::RC_ZERO; // R06
      end
      dpo_pkg::RC_ZERO: begin
        if (rc.at_zero) begin
          nxt_state = dpo_pkg::RC_DIVRST;
          nxt_cnt = dpo_pkg::DIVRST_CYC_W8;
        end
      end
      dpo_pkg::RC_DIVRST: begin
        nxt_cnt = cnt_ff - 8'h01;
        if (cnt_ff == 8'h01) begin
          nxt_state = dpo_pkg::RC_BACK;
        end
      end
      dpo_pkg::RC_BACK: begin
        if (rc.at_target) begin
          nxt_state = dpo_pkg::RC_EXIT; // R07
        end
      end
      dpo_pkg::RC_EXIT: begin
        nxt_state = dpo_pkg::RC_IDLE;
      end
      default: begin
        nxt_state = dpo_pkg::RC_IDLE;
      end
    endcase
  end

  // ---------------------------------------------------------------------------
  // State and decoded outputs
  // ---------------------------------------------------------------------------
  // Outputs except done are decoded from the next state so that they line up with it; done follows one cycle after RC_EXIT.
  always_ff @(posedge mclk) begin
    if (rst) begin
      state_ff <= dpo_pkg::RC_IDLE;
      cnt_ff <= 8'h00;
      busy_ff <= 1'b0;
      mh_ff <= 1'b0;
      rz_ff <= 1'b0;
      dr_ff <= 1'b0;
      done_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      cnt_ff <= nxt_cnt;
      busy_ff <= (nxt_state != dpo_pkg::RC_IDLE);
      mh_ff <= (nxt_state != dpo_pkg::RC_IDLE) && (nxt_state != dpo_pkg::RC_EXIT);
      rz_ff <= (nxt_state == dpo_pkg::RC_ZERO) || (nxt_state == dpo_pkg::RC_DIVRST);
      dr_ff <= (nxt_state == dpo_pkg::RC_DIVRST);
      done_ff <= (state_ff == dpo_pkg::RC_EXIT); // R20
    end
  end

  assign rc.busy = busy_ff;
  assign rc.mini_holdover = mh_ff;
  assign rc.ramp_zero = rz_ff;
  assign rc.divider_reset = dr_ff;
  assign rc.done = done_ff;

  // ---------------------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------------------
  a_recal_start_holdover: assert property (@(posedge mclk) disable iff (rst) // R05
    (state_ff == dpo_pkg::RC_IDLE && rc.start) |=> ##1 mh_ff)
    else $error("Recalibration did not enter mini-holdover.");
  a_divrst_after_zero: assert property (@(posedge mclk) disable iff (rst) // R06
    $rose(dr_ff) |-> $past(rz_ff) && mh_ff)
    else $error("Divider reset outside zero-offset holdover.");

endmodule

/* dpo_far.sv */
// Far-side model of the reference inputs and the second loop.
`timescale 1ns/1ps
module dpo_far (
  input wire logic mclk,
  input wire logic [1:0] state_req,
  output logic [1:0] loop_state,
  output logic phase_sample_valid,
  output logic signed [15:0] own_ref_phase,
  output logic signed [15:0] feedback_phase,
  output logic signed [15:0] other_ref_phase,
  output logic signed [15:0] other_out_phase
);
  logic [1:0] cnt_ff = 2'h0;
  // Both references hold one rate, so the detector compares equal frequencies.
  assign own_ref_phase = 16'sh0064;
  assign other_ref_phase = 16'shffec;
  assign feedback_phase = 16'sh0028;
  assign other_out_phase = 16'sh000a;
  assign loop_state = state_req;
  assign phase_sample_valid = cnt_ff == 2'h3;
  // A phase sample every fourth cycle keeps the averager busy.
  always @(posedge mclk) begin
    cnt_ff <= cnt_ff + 2'h1;
  end
endmodule

/* testbench.sv */
// Self-checking bench for the loop offset and measurement block.
`timescale 1ns/1ps
module testbench;
  logic mclk = 1'b0, rst = 1'b1, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic s_axi_arready, s_axi_rvalid, phase_sample_valid, lock_enable, mini_holdover, divider_reset, ref_invalid;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rv;
  logic [3:0] s_axi_wstrb = 4'hf, forced_reference_select, loop_bw_select;
  logic [1:0] s_axi_bresp, s_axi_rresp, rs, loop_state, state_req = 2'h3;
  logic [2:0] pd_select;
  logic signed [15:0] own_ref_phase, feedback_phase, other_ref_phase, other_out_phase;
  logic signed [16:0] fb_phase_offset;
  // Rows hold the control word, then the expected detector select and lock enable.
  logic [15:0] rows [4] = '{16'h0003, 16'h0044, 16'h0089, 16'ha503};
  int err_count = 0, check_count = 0, n;
  dpo_far i_dpo_far (.*);
  dpo_dpll i_dpo_dpll (.*);
  // Free-running 100 MHz clock.
  always #5 mclk = ~mclk;
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_count++;
      $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  // Each channel is released only at the edge that takes it.
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge mclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_awvalid || s_axi_wvalid || !s_axi_bvalid);
    s_axi_bready <= 1'b0;
    rs = s_axi_bresp;
    @(posedge mclk);
  endtask
  task automatic rd(input logic [7:0] a);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge mclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_arvalid || !s_axi_rvalid);
    s_axi_rready <= 1'b0;
    rv = s_axi_rdata;
    rs = s_axi_rresp;
    @(posedge mclk);
  endtask
  // The ramp takes many cycles at low bandwidth, so the wait is generous.
  task automatic wfb(input logic signed [16:0] v);
    for (n = 0; n < 1200 && fb_phase_offset !== v; n++) @(posedge mclk);
    chk(32'(fb_phase_offset), 32'(v));
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // Watchdog sized well beyond the few thousand cycles the tests need.
  initial begin
    repeat (20000) @(posedge mclk);
    err_count++;
    stop_test();
  end
  // Main sequence: reset and map, mode table, offset and recalibration, frequency, hard limit, then mid-run reset cases.
  initial begin
    repeat (16) @(posedge mclk);
    rst <= 1'b0;
    chk(32'(pd_select), 32'h1);
    @(posedge mclk);
    rd(dpo_pkg::ADDR_HARDLIM);
    chk(rv, 32'h7fffffff);
    rd(8'h1c);
    chk(rv | 32'(rs), 32'h2);
    wr(8'h1c, 32'h1);
    chk(32'(rs), 32'h2);
    $display("reset and map test done");
    foreach (rows[i]) begin
      wr(dpo_pkg::ADDR_CTRL, 32'(rows[i][15:4]));
      repeat (2) @(posedge mclk);
      chk(32'({pd_select, lock_enable}), 32'(rows[i][3:0]));
      chk(32'({loop_bw_select, forced_reference_select}), 32'(rows[i][15:8]));
    end
    $display("mode table done");
    wr(dpo_pkg::ADDR_OFFSET, 32'd40000);
    rd(dpo_pkg::ADDR_OFFSET);
    chk(rv, 32'd33333);
    wfb(17'sd33333);
    wr(dpo_pkg::ADDR_CTRL, 32'ha51);
    wfb(17'sd0);
    wr(dpo_pkg::ADDR_CTRL, 32'ha50);
    wfb(17'sd33333);
    state_req <= 2'h0;
    wr(dpo_pkg::ADDR_OFFSET, 32'hfffffc18);
    repeat (60) @(posedge mclk);
    chk(32'(fb_phase_offset), 32'd33333);
    state_req <= 2'h2;
    wfb(-17'sd1000);
    $display("offset tests done");
    wr(dpo_pkg::ADDR_CTRL, 32'h052);
    for (n = 0; n < 50 && mini_holdover !== 1'b1; n++) @(posedge mclk);
    chk(32'(mini_holdover), 32'h1);
    wr(dpo_pkg::ADDR_OFFSET, 32'd500);
    wfb(17'sd0);
    for (n = 0; n < 50 && divider_reset !== 1'b1; n++) @(posedge mclk);
    for (n = 0; n < 50 && divider_reset === 1'b1; n++) @(posedge mclk);
    chk(32'(n), 32'(dpo_pkg::DIVRST_CYC));
    chk(32'(mini_holdover), 32'h1);
    for (n = 0; n < 1200 && mini_holdover !== 1'b0; n++) @(posedge mclk);
    chk(32'(fb_phase_offset), 32'd500);
    repeat (4) @(posedge mclk);
    rd(dpo_pkg::ADDR_CTRL);
    chk(rv, 32'h050);
    $display("recalibration test done");
    state_req <= 2'h0;
    repeat (3) @(posedge mclk);
    rd(dpo_pkg::ADDR_FREQ);
    n = rv;
    wr(dpo_pkg::ADDR_MCADJ, 32'h100);
    rd(dpo_pkg::ADDR_FREQ);
    chk(rv - 32'(n), 32'h100);
    $display("frequency test done");
    state_req <= 2'h3;
    wr(dpo_pkg::ADDR_HARDLIM, 32'h0);
    for (n = 0; n < 400 && ref_invalid !== 1'b1; n++) @(posedge mclk);
    chk(32'(ref_invalid), 32'h1);
    $display("hard limit test done");
    rst <= 1'b1;
    repeat (2) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    chk(32'(fb_phase_offset), 32'h0);
    rd(dpo_pkg::ADDR_HARDLIM);
    chk(rv, 32'h7fffffff);
    $display("mid-run reset test done");
    stop_test();
  end
endmodule
